/* File: dv/nip_cpu_model.sv */
// cpu-side partner: classic wishbone master with single-cycle tasks
// assumes a slave on clk_i that acks every request it takes
`timescale 1ns/100ps

module nip_cpu_model
	import nip_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        wb_ack_i,
	output logic             wb_cyc_o,
	output logic             wb_stb_o,
	output logic             wb_we_o,
	output logic      [7:0]  wb_adr_o,
	output logic      [3:0]  wb_sel_o,
	output logic      [31:0] wb_dat_o,
	output logic             hung_o
);
	// ==========================================================
	// idle bus at time zero
	initial
	begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o  = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0;
		hung_o   = 1'b0;
	end

	// ==========================================================
	// one classic cycle; ack is sampled on the rising edges while the request stands
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o  <= we;
		wb_adr_o <= adr;
		wb_sel_o <= 4'h3;
		wb_dat_o <= wd;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_i !== 1'b1 && n < 50);
		// data taken and request dropped at the very edge that saw ack high
		rd = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		if (n >= 50)
			hung_o <= 1'b1;
	endtask

	// ==========================================================
	// command launch; old error flags cleared first so it is not refused
	task automatic launch(input logic [15:0] adr, input logic [7:0] code, input logic [7:0] dat);
		logic [31:0] v;
		xfer(1'b1, ADR_STATUS, 32'h30, v);
		xfer(1'b1, ADR_CMD_ADDR, {16'h0, adr}, v);
		xfer(1'b1, ADR_CMD_DATA, {16'h0, code, dat}, v);
		xfer(1'b1, ADR_STATUS, 32'h80, v);
	endtask
endmodule // nip_cpu_model

/* File: dv/tb_nip_top.sv */
// self-checking bench for the interrupt and protection block
// assumes the partner master model and a 100 MHz clock
`timescale 1ns/100ps

module tb_nip_top;
	import nip_pkg::*;

	// ==========================================================
	// stimulus and bus nets
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        por = 1'b1;
	logic [1:0]  ecc = 2'b00;
	wire logic        wb_cyc, wb_stb, wb_we, wb_ack, hung, cmd_irq, err_irq;
	wire logic [7:0]  wb_adr;
	wire logic [3:0]  wb_sel;
	wire logic [31:0] wb_wdat, wb_rdat;
	int bad_count = 0;
	int checks_done = 0;
	logic [15:0] hb [4] = '{HI_BASE_2K, HI_BASE_4K, HI_BASE_8K, HI_BASE_16K};
	logic [15:0] ok_move = 16'hF623;
	logic [7:0]  b;

	initial
	begin
		forever #5 clk = ~clk;
	end

	nip_top i_nip_top (.clk_i(clk), .rst_i(rst), .por_i(por), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .ecc_single_i(ecc[0]),
		.ecc_double_i(ecc[1]), .cmd_irq_o(cmd_irq), .err_irq_o(err_irq));

	nip_cpu_model i_nip_cpu_model (.clk_i(clk), .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack),
		.wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr),
		.wb_sel_o(wb_sel), .wb_dat_o(wb_wdat), .hung_o(hung));

	// ==========================================================
	// comparison, verdict and helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("counts: %0d compared, %0d wrong", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic do_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// load takes three edges, completion flag is set at the third
		repeat (5) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		i_nip_cpu_model.xfer(1'b1, a, d, v);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		i_nip_cpu_model.xfer(1'b0, a, 32'h0, v);
		check(v & m, e);
	endtask

	task automatic irq_chk(input logic [1:0] e);
		repeat (2) @(negedge clk);
		check({30'h0, err_irq, cmd_irq}, {30'h0, e});
	endtask

	// polls, bounded, until the running command has finished
	task automatic wait_idle;
		logic [31:0] v;
		int n;
		n = 0;
		v = 32'h0;
		while (v[7] !== 1'b1 && n < 30)
		begin
			i_nip_cpu_model.xfer(1'b0, ADR_STATUS, 32'h0, v);
			n++;
		end
		check({31'h0, v[7]}, 32'h1);
	endtask

	task automatic launch_chk(input logic [15:0] a, input logic [7:0] c, input logic viol);
		i_nip_cpu_model.launch(a, c, 8'h5A);
		rd_chk(ADR_STATUS, 32'hB0, viol ? 32'h90 : 32'h00);
		wait_idle;
	endtask

	// ==========================================================
	// watchdog sized well above the thousand or so cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		finish_test;
	end

	// ==========================================================
	// test sequence
	initial
	begin
		// power-on clear and reset held together for four cycles
		repeat (4) @(posedge clk);
		por <= 1'b0;
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		// erased image: no protection anywhere, command idle
		rd_chk(ADR_STATUS, 32'hB0, 32'h80);
		rd_chk(ADR_FLASH_PROT, 32'hBF, 32'hBF);
		rd_chk(ADR_EE_PROT, 32'h87, 32'h87);
		rd_chk(8'h40, 32'hFFFFFFFF, 32'h0);
		$display("test reset values done");

		irq_chk(2'b00);
		wr(ADR_CONFIG, 32'h80);
		irq_chk(2'b01);
		launch_chk(16'h3000, CMD_PROG_FLASH, 1'b0);
		irq_chk(2'b01);
		wr(ADR_CONFIG, 32'h00);
		irq_chk(2'b00);
		$display("test command irq done");

		// unknown command code is refused as an access error, nothing runs
		i_nip_cpu_model.launch(16'h3000, 8'h01, 8'h00);
		rd_chk(ADR_STATUS, 32'hB0, 32'hA0);
		wr(ADR_STATUS, 32'h20);
		rd_chk(ADR_STATUS, 32'hB0, 32'h80);
		$display("test access error done");

		// each fault flag is sticky, masked by its own enable, cleared by one
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk);
			ecc[i] <= 1'b1;
			@(posedge clk);
			ecc[i] <= 1'b0;
			rd_chk(ADR_ERR_STATUS, 32'h3, 32'(1 << i));
			irq_chk(2'b00);
			wr(ADR_ERR_CONFIG, 32'(1 << i));
			irq_chk(2'b10);
			wr(ADR_ERR_STATUS, 32'(1 << i));
			irq_chk(2'b00);
			rd_chk(ADR_ERR_STATUS, 32'h3, 32'h0);
			wr(ADR_ERR_CONFIG, 32'h0);
		end
		$display("test fault irq done");

		// every move from every scenario, reaching each start from scenario 3
		for (int f = 0; f < 4; f++)
			for (int t = 0; t < 4; t++)
			begin
				do_reset;
				wr(ADR_FLASH_PROT, {24'h0, f[1], 1'b0, f[0], 5'h0});
				wr(ADR_FLASH_PROT, {24'h0, t[1], 1'b0, t[0], 5'h0});
				b = ok_move[f * 4 + t] ? {t[1], 1'b0, t[0], 5'h0} : {f[1], 1'b0, f[0], 5'h0};
				rd_chk(ADR_FLASH_PROT, 32'hA0, {24'h0, b});
			end
		$display("test scenario moves done");

		// high range sizes, probed just inside and just below each base
		for (int h = 0; h < 4; h++)
		begin
			do_reset;
			wr(ADR_FLASH_PROT, {24'h0, 3'b100, h[1:0], 3'b000});
			launch_chk(hb[h], CMD_PROG_FLASH, 1'b1);
			launch_chk(hb[h] - 16'h1, CMD_ERASE_SECT, 1'b0);
		end
		do_reset;
		wr(ADR_FLASH_PROT, 32'h20);
		launch_chk(FLASH_BASE, CMD_PROG_FLASH, 1'b1);
		launch_chk(16'hFFFF, CMD_ERASE_SECT, 1'b1);
		do_reset;
		wr(ADR_FLASH_PROT, 32'h00);
		launch_chk(FLASH_BASE, CMD_ERASE_SECT, 1'b1);
		launch_chk(HI_BASE_2K, CMD_PROG_FLASH, 1'b0);
		$display("test flash ranges done");

		// whole upper phrase rewritten, reserved bytes kept erased
		do_reset;
		for (int i = 8; i < 16; i++)
		begin
			b = (i == 12) ? 8'h20 : (i == 13) ? 8'h05 : ERASED_BYTE;
			i_nip_cpu_model.launch(CFG_BASE + 16'(i), CMD_PROG_FLASH, b);
			wait_idle;
		end
		do_reset;
		rd_chk(ADR_FLASH_PROT, 32'hBF, 32'h20);
		rd_chk(ADR_EE_PROT, 32'h87, 32'h05);
		launch_chk(EE_BASE + 16'hBF, CMD_PROG_EE, 1'b1);
		launch_chk(EE_BASE + 16'hC0, CMD_ERASE_EE, 1'b0);
		launch_chk(EE_BASE, CMD_ERASE_EE, 1'b1);
		$display("test loaded protection done");

		check({31'h0, hung}, 32'h0);
		finish_test;
	end
endmodule // tb_nip_top

/* File: src/nip_cfg_mem.sv */
// nonvolatile configuration field image, 16 bytes, registered read port
// assumes por_i is a synchronous power-on clear that stands for an erased part
`timescale 1ns/100ps

module nip_cfg_mem
	import nip_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       por_i,
	input  wire logic       wr_en_i,
	input  wire logic [3:0] wr_idx_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic [3:0] rd_idx_i,
	output logic      [7:0] rd_data_o
);

	logic [7:0] cells [16];

	// ==========================================================
	// storage; rst_i of the block does not touch it, only power-on does
	always_ff @(posedge clk_i)
	begin
		if (por_i)
		begin
			for (int i = 0; i < 16; i++)
			begin
				cells[i] <= ERASED_BYTE;
			end
		end
		else if (wr_en_i)
		begin
			cells[wr_idx_i] <= wr_data_i;
		end
	end

	// read data one cycle after the index
	always_ff @(posedge clk_i)
	begin
		rd_data_o <= cells[rd_idx_i];
	end

endmodule // nip_cfg_mem

/* File: src/nip_pkg.sv */
// constants, register map and state type of the nvm interrupt and protection block
// assumes a 32-bit classic wishbone slave port and a 16-bit global address space
// What this block does
// - command irq is high while command-complete flag and its enable are both set
// - ecc double-bit read fault sets the double-fault flag, with its own enable
// - ecc single-bit read fault sets the single-fault flag, with its own enable
// - one error irq, separate from command irq, from either enabled fault flag
// - program or erase aimed at an active protected flash region is refused
// - two flash regions: high one growing down from 0xFFFF, low one the rest
// - reset sequence loads flash protection register from config byte 0xFF7C
// - open/disable: 11 none, 10 high range, 01 all flash, 00 all but high
// - disallowed scenario writes ignored: 0->0,1; 1->1; 2->1,2; 3->any
// - high size 00..11 gives 2, 4, 8, 16 KB ending at 0xFFFF
// - reset sequence loads eeprom open bit and size from config byte 0xFF7D
// - eeprom protected from 0x3100 upward, 32*(n+1) bytes for size n
// - config field: 8 key bytes, 4 reserved, then flash_protect_reg, eprot, nv, security
// - software may rewrite the protection register later, subject to add-only moves

package nip_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] ADR_STATUS     = 8'h00;
	localparam logic [7:0] ADR_CONFIG     = 8'h04;
	localparam logic [7:0] ADR_ERR_STATUS = 8'h08;
	localparam logic [7:0] ADR_ERR_CONFIG = 8'h0C;
	localparam logic [7:0] ADR_FLASH_PROT = 8'h10;
	localparam logic [7:0] ADR_EE_PROT    = 8'h14;
	localparam logic [7:0] ADR_CMD_ADDR   = 8'h18;
	localparam logic [7:0] ADR_CMD_DATA   = 8'h1C;

	// ==========================================================
	// field positions
	localparam int BIT_COMMAND_COMPLETE_FLAG    = 7;
	localparam int BIT_ACCESS_ERROR_FLAG  = 5;
	localparam int BIT_PVIOL   = 4;
	localparam int BIT_COMMAND_COMPLETE_IRQ_ENABLE    = 7;
	localparam int BIT_DFAULT  = 1;
	localparam int BIT_SFAULT  = 0;
	localparam int BIT_FOPEN   = 7;
	localparam int BIT_HDIS    = 5;
	localparam int POS_HS      = 3;
	localparam int POS_LS      = 0;
	localparam int BIT_EOPEN   = 7;
	localparam int POS_DPS     = 0;

	// ==========================================================
	// configuration field, index within the 16-byte block at 0xFF70
	localparam logic [15:0] CFG_BASE     = 16'hFF70;
	localparam logic [3:0]  CFG_IDX_FLASH_PROTECT_REG = 4'hC;
	localparam logic [3:0]  CFG_IDX_EPROT = 4'hD;
	localparam logic [7:0]  ERASED_BYTE   = 8'hFF;

	// ==========================================================
	// address ranges
	localparam logic [15:0] FLASH_BASE = 16'h4000;
	localparam logic [15:0] HI_BASE_2K  = 16'hF800;
	localparam logic [15:0] HI_BASE_4K  = 16'hF000;
	localparam logic [15:0] HI_BASE_8K  = 16'hE000;
	localparam logic [15:0] HI_BASE_16K = 16'hC000;
	localparam logic [15:0] EE_BASE    = 16'h3100;

	// ==========================================================
	// commands and timing
	localparam logic [7:0] CMD_PROG_FLASH  = 8'h06;
	localparam logic [7:0] CMD_ERASE_SECT  = 8'h0A;
	localparam logic [7:0] CMD_PROG_EE     = 8'h11;
	localparam logic [7:0] CMD_ERASE_EE    = 8'h12;
	localparam int         CMD_TIME_NS     = 80;
	localparam int         CLK_PERIOD_NS   = 10;
	localparam logic [3:0] CMD_CYCLES      = 4'((CMD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ==========================================================
	// controller states, gray along load -> idle -> exec
	typedef enum logic [2:0] {
		ST_LD_FP  = 3'h0,
		ST_LD_EP  = 3'h1,
		ST_LD_FIN = 3'h3,
		ST_IDLE   = 3'h2,
		ST_EXEC   = 3'h6
	} nip_state_type;

endpackage

/* File: src/nip_top.sv */
// nvm interrupt and protection block: flags, irqs, reset-time protection load,
// add-only protection moves and protected-range check on command launch
// assumes a classic wishbone master on clk_i, ecc pulses from same-clock logic
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps

module nip_top
	import nip_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        por_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        ecc_single_i,
	input  wire logic        ecc_double_i,
	output logic             cmd_irq_o,
	output logic             err_irq_o
);

	nip_state_type state;
	logic          command_complete_flag;
	logic          access_error_flag;
	logic          pviol;
	logic          command_complete_irq_enable;
	logic          dfault;
	logic          sfault;
	logic          dfault_en;
	logic          sfault_en;
	logic          f_open;
	logic          f_hdis;
	logic [1:0]    f_hs;
	logic [2:0]    f_ls;
	logic          e_open;
	logic [2:0]    e_dps;
	logic [15:0]   cmd_addr;
	logic [7:0]    cmd_data;
	logic [7:0]    cmd_code;
	logic [3:0]    exec_cnt;
	logic [7:0]    cfg_rd;
	logic [3:0]    cfg_rd_idx;
	logic          cfg_wr;

	// ==========================================================
	// bus decode
	logic       wb_req;
	logic       wr_cyc;
	logic [7:0] wb_off;
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_cyc = wb_req && wb_we_i && wb_sel_i[0];
	assign wb_off = {wb_adr_i[7:2], 2'b00};

	logic wr_status;
	logic wr_flash_protect_reg;
	assign wr_status = wr_cyc && (wb_off == ADR_STATUS);
	assign wr_flash_protect_reg  = wr_cyc && (wb_off == ADR_FLASH_PROT);

	// ==========================================================
	// protection decode
	logic [1:0]  scen_now;
	logic [1:0]  scen_req;
	logic        scen_ok;
	logic [15:0] hi_base;
	logic        in_flash;
	logic        in_high;
	logic        flash_hit;
	logic [15:0] ee_last;
	logic        ee_hit;
	logic        prot_hit;

	assign scen_now = {f_open, f_hdis};
	assign scen_req = {wb_dat_i[BIT_FOPEN], wb_dat_i[BIT_HDIS]};

	// add-only moves between scenarios
	always_comb
	begin
		unique case (scen_now)
			2'd0: scen_ok = (scen_req == 2'd0) || (scen_req == 2'd1);
			2'd1: scen_ok = (scen_req == 2'd1);
			2'd2: scen_ok = (scen_req == 2'd1) || (scen_req == 2'd2);
			2'd3: scen_ok = 1'b1;
		endcase
	end

	// high region grows down from the top address
	always_comb
	begin
		unique case (f_hs)
			2'd0: hi_base = HI_BASE_2K;
			2'd1: hi_base = HI_BASE_4K;
			2'd2: hi_base = HI_BASE_8K;
			2'd3: hi_base = HI_BASE_16K;
		endcase
	end

	assign in_flash = cmd_addr >= FLASH_BASE;
	assign in_high  = cmd_addr >= hi_base;

	always_comb
	begin
		unique case (scen_now)
			2'd3: flash_hit = 1'b0;
			2'd2: flash_hit = in_high;
			2'd1: flash_hit = in_flash;
			2'd0: flash_hit = in_flash && !in_high;
		endcase
	end

	// eeprom window in 32-byte steps, open bit set means unprotected
	assign ee_last  = EE_BASE + {8'h00, e_dps, 5'h1F};
	assign ee_hit   = !e_open && (cmd_addr >= EE_BASE) && (cmd_addr <= ee_last);
	assign prot_hit = flash_hit || ee_hit;

	// ==========================================================
	// command launch; a launch while errors stand is an access error
	logic launch_try;
	logic cmd_known;
	logic launch_ok;
	logic launch_bad;
	logic launch_prot;
	assign launch_try  = wr_status && wb_dat_i[BIT_COMMAND_COMPLETE_FLAG] && command_complete_flag && (state == ST_IDLE);
	assign cmd_known   = (cmd_code == CMD_PROG_FLASH) || (cmd_code == CMD_ERASE_SECT) ||
			     (cmd_code == CMD_PROG_EE) || (cmd_code == CMD_ERASE_EE);
	assign launch_bad  = launch_try && (access_error_flag || pviol || !cmd_known);
	assign launch_prot = launch_try && !launch_bad && prot_hit;
	assign launch_ok   = launch_try && !launch_bad && !prot_hit;

	// ==========================================================
	// controller: reset-time load, then idle and command execution
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state    <= ST_LD_FP;
			exec_cnt <= 4'h0;
		end
		else
		begin
			unique case (state)
				ST_LD_FP:  state <= ST_LD_EP;
				ST_LD_EP:  state <= ST_LD_FIN;
				ST_LD_FIN: state <= ST_IDLE;
				ST_IDLE:
				begin
					if (launch_ok)
					begin
						state    <= ST_EXEC;
						exec_cnt <= CMD_CYCLES;
					end
				end
				ST_EXEC:
				begin
					exec_cnt <= exec_cnt - 4'h1;
					if (exec_cnt == 4'h1)
					begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_LD_FP;
			endcase
		end
	end

	// read index follows the load sequence, data lands one state later
	assign cfg_rd_idx = (state == ST_LD_FP) ? CFG_IDX_FLASH_PROTECT_REG : CFG_IDX_EPROT;

	// only the config field image is stored here; other flash lives elsewhere
	assign cfg_wr = (state == ST_EXEC) && (exec_cnt == 4'h1) &&
			(cmd_code == CMD_PROG_FLASH) && (cmd_addr[15:4] == CFG_BASE[15:4]);

	nip_cfg_mem u_cfg_mem (
		.clk_i     (clk_i),
		.por_i     (por_i),
		.wr_en_i   (cfg_wr),
		.wr_idx_i  (cmd_addr[3:0]),
		.wr_data_i (cmd_data),
		.rd_idx_i  (cfg_rd_idx),
		.rd_data_o (cfg_rd)
	);

	// ==========================================================
	// status flags; hardware set wins over software clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			command_complete_flag   <= 1'b0;
			access_error_flag <= 1'b0;
			pviol  <= 1'b0;
		end
		else
		begin
			if (state == ST_LD_FIN)
				command_complete_flag <= 1'b1;
			else if (launch_ok)
				command_complete_flag <= 1'b0;
			else if (state == ST_EXEC && exec_cnt == 4'h1)
				command_complete_flag <= 1'b1;
			if (launch_bad)
				access_error_flag <= 1'b1;
			else if (wr_status && wb_dat_i[BIT_ACCESS_ERROR_FLAG])
				access_error_flag <= 1'b0;
			if (launch_prot)
				pviol <= 1'b1;
			else if (wr_status && wb_dat_i[BIT_PVIOL])
				pviol <= 1'b0;
		end
	end

	// ecc fault flags, write one to clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dfault <= 1'b0;
			sfault <= 1'b0;
		end
		else
		begin
			if (ecc_double_i)
				dfault <= 1'b1;
			else if (wr_cyc && wb_off == ADR_ERR_STATUS && wb_dat_i[BIT_DFAULT])
				dfault <= 1'b0;
			if (ecc_single_i)
				sfault <= 1'b1;
			else if (wr_cyc && wb_off == ADR_ERR_STATUS && wb_dat_i[BIT_SFAULT])
				sfault <= 1'b0;
		end
	end

	// ==========================================================
	// enables and command words
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			command_complete_irq_enable      <= 1'b0;
			dfault_en <= 1'b0;
			sfault_en <= 1'b0;
			cmd_addr  <= 16'h0000;
			cmd_data  <= 8'h00;
			cmd_code  <= 8'h00;
		end
		else
		begin
			if (wr_cyc && wb_off == ADR_CONFIG)
				command_complete_irq_enable <= wb_dat_i[BIT_COMMAND_COMPLETE_IRQ_ENABLE];
			if (wr_cyc && wb_off == ADR_ERR_CONFIG)
			begin
				dfault_en <= wb_dat_i[BIT_DFAULT];
				sfault_en <= wb_dat_i[BIT_SFAULT];
			end
			// parameters locked while a command runs
			if (wr_cyc && wb_off == ADR_CMD_ADDR && command_complete_flag && wb_sel_i[1])
				cmd_addr <= wb_dat_i[15:0];
			if (wr_cyc && wb_off == ADR_CMD_DATA && command_complete_flag && wb_sel_i[1])
			begin
				cmd_data <= wb_dat_i[7:0];
				cmd_code <= wb_dat_i[15:8];
			end
		end
	end

	// ==========================================================
	// protection registers: loaded at reset, then add-only writes to the flash one
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			f_open <= 1'b0;
			f_hdis <= 1'b0;
			f_hs   <= 2'b00;
			f_ls   <= 3'b000;
			e_open <= 1'b0;
			e_dps  <= 3'b000;
		end
		else if (state == ST_LD_EP)
		begin
			f_open <= cfg_rd[BIT_FOPEN];
			f_hdis <= cfg_rd[BIT_HDIS];
			f_hs   <= cfg_rd[POS_HS +: 2];
			f_ls   <= cfg_rd[POS_LS +: 3];
		end
		else if (state == ST_LD_FIN)
		begin
			e_open <= cfg_rd[BIT_EOPEN];
			e_dps  <= cfg_rd[POS_DPS +: 3];
		end
		else if (wr_flash_protect_reg && scen_ok)
		begin
			f_open <= wb_dat_i[BIT_FOPEN];
			f_hdis <= wb_dat_i[BIT_HDIS];
			// sizes only move while no flash is protected (scenario 3)
			if (scen_now == 2'd3)
			begin
				f_hs <= wb_dat_i[POS_HS +: 2];
				f_ls <= wb_dat_i[POS_LS +: 3];
			end
		end
	end

	// ==========================================================
	// interrupt outputs, no extra gating: the cpu masks them itself
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cmd_irq_o <= 1'b0;
			err_irq_o <= 1'b0;
		end
		else
		begin
			cmd_irq_o <= command_complete_flag && command_complete_irq_enable;
			err_irq_o <= (dfault && dfault_en) || (sfault && sfault_en);
		end
	end

	// ==========================================================
	// wishbone slave: ack one cycle after the request, unmapped reads zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req && !wb_we_i)
			begin
				unique case (wb_off)
					ADR_STATUS:     wb_dat_o <= {24'h0, command_complete_flag, 1'b0, access_error_flag, pviol, 4'h0};
					ADR_CONFIG:     wb_dat_o <= {24'h0, command_complete_irq_enable, 7'h00};
					ADR_ERR_STATUS: wb_dat_o <= {30'h0, dfault, sfault};
					ADR_ERR_CONFIG: wb_dat_o <= {30'h0, dfault_en, sfault_en};
					ADR_FLASH_PROT: wb_dat_o <= {24'h0, f_open, 1'b0, f_hdis, f_hs, f_ls};
					ADR_EE_PROT:    wb_dat_o <= {24'h0, e_open, 4'h0, e_dps};
					ADR_CMD_ADDR:   wb_dat_o <= {16'h0, cmd_addr};
					ADR_CMD_DATA:   wb_dat_o <= {16'h0, cmd_code, cmd_data};
					default:        wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================================
	// assertions
	a_cmd_irq_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		(command_complete_flag && command_complete_irq_enable) |=> cmd_irq_o) else $error("command irq missing");
	a_dfault_sets: assert property (@(posedge clk_i) disable iff (rst_i)
		ecc_double_i |=> dfault ##1 (err_irq_o == $past(dfault_en || (sfault && sfault_en))))
		else $error("double fault not flagged");
	a_sfault_sets: assert property (@(posedge clk_i) disable iff (rst_i)
		ecc_single_i |=> sfault) else $error("single fault not flagged");
	a_err_irq_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		!((dfault && dfault_en) || (sfault && sfault_en)) |=> !err_irq_o)
		else $error("error irq without enabled fault");
	a_prot_refused: assert property (@(posedge clk_i) disable iff (rst_i)
		launch_prot |=> pviol && command_complete_flag && state == ST_IDLE) else $error("protected launch ran");
	a_scen_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_flash_protect_reg && !scen_ok && state == ST_IDLE) |=> $stable(scen_now))
		else $error("illegal scenario taken");
	a_flash_protect_reg_loaded: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_LD_EP |=> f_open == $past(cfg_rd[BIT_FOPEN]) && f_hs == $past(cfg_rd[4:3]))
		else $error("flash protection not loaded");
	a_eprot_loaded: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_LD_FIN |=> e_dps == $past(cfg_rd[2:0]) && command_complete_flag)
		else $error("eeprom protection not loaded");
	a_high_16k: assert property (@(posedge clk_i) disable iff (rst_i)
		(scen_now == 2'd2 && f_hs == 2'd3 && cmd_addr == 16'hC000) |-> flash_hit)
		else $error("16k high range wrong");
	a_cmd_finish: assert property (@(posedge clk_i) disable iff (rst_i)
		launch_ok |=> !command_complete_flag ##[1:12] command_complete_flag) else $error("command never completes");

endmodule // nip_top
